// >>> pcl_map.svh
// Register offsets, reset values and timing figures of the limit block
`ifndef PCL_MAP_SVH
`define PCL_MAP_SVH

// Register byte offsets
`define PCL_OFS_CTRL       8'h00
`define PCL_OFS_SLOPE      8'h04
`define PCL_OFS_ZERO       8'h08
`define PCL_OFS_RSTART     8'h0c
`define PCL_OFS_REND       8'h10
`define PCL_OFS_PDC        8'h14
`define PCL_OFS_STEP       8'h18
`define PCL_OFS_STATUS     8'h1c
`define PCL_OFS_LIMIT      8'h20

// Reset values
`define PCL_RST_SLOPE      16'h4e20
`define PCL_RST_ZERO       8'h4f
`define PCL_RST_RSTART     10'h020
`define PCL_RST_REND       10'h100
`define PCL_RST_PDC        10'h015
`define PCL_RST_STEP       10'h001

// Fixed arithmetic figures
`define PCL_OFS_SHIFT      16
`define PCL_ADC_BASE_MV    1200
`define PCL_ADC_NUM        160
`define PCL_ADC_DEN        1000
`define PCL_ADC_MAX        9'h0ff
`define PCL_LL_UA          70
`define PCL_HL_UA          370

// Times, their units and the clock rate
`define PCL_CLK_MHZ        100
`define PCL_LEB_NS         269
`define PCL_RS_NS          600
`define PCL_BASE_NS        52140
`define PCL_NS_PER_US      1000
`endif

// >>> pcl_pkg.sv
// Types shared by the peak current limit block
package pcl_pkg;
  // AHB-Lite address phase captured for the data phase
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
  } pcl_aphase_s;

  // Soft-start ramp states
  typedef enum logic [1:0] {
    PCL_SS_IDLE = 2'b01,
    PCL_SS_RAMP = 2'b10
  } pcl_ss_e;
endpackage

// >>> pcl_limit.sv
// Peak current limit computation, soft-start, blanking, AHB-Lite registers
`timescale 1ns/1ps
`include "pcl_map.svh"

// Summary of operation
// - Subtract the output-voltage offset from the frequency-law peak command.
// - Offset equals slope gain times zero level minus sample, over 65536.
// - Offset zero at the zero level, largest at the minimum sense code.
// - Remove the fixed 1.2 V level from the aux sense before conversion.
// - Converted sense code saturates at 0 and 255 outside the range.
// - Bulk sense current is the measurement used as bulk voltage.
// - Switch turns off when sensed current reaches the comparator threshold.
// - Threshold falls linearly with bulk current between the line corners.
// - Soft-start ramp runs at first startup and every auto-restart.
// - During soft-start the limit rises one step per base period.
// - Ramp starts at the start level, ends at the latest at end level.
// - Ramp values are not corrected for propagation delay.
// - Soft-start ends when feedback falls below its threshold.
// - Comparator output ignored for a fixed time after each turn-on.
// - Blanking applies only to the cycle peak comparator.
// - Aux sense sampled when ringing suppression after turn-off ends.
module pcl_limit #(
  parameter int BASE_CYCLES = (`PCL_BASE_NS * `PCL_CLK_MHZ)
                              / `PCL_NS_PER_US,
  parameter int LW          = 10
) (
  // Clock and reset
  input  wire logic          hclk,
  input  wire logic          hresetn,
  // AHB-Lite slave
  input  wire logic          hsel,
  input  wire logic [31:0]   haddr,
  input  wire logic [1:0]    htrans,
  input  wire logic          hwrite,
  input  wire logic [2:0]    hsize,
  input  wire logic [31:0]   hwdata,
  input  wire logic          hready,
  output logic               hreadyout,
  output logic               hresp,
  output logic [31:0]        hrdata,
  // Power stage and analogue sense
  input  wire logic          gate_on,
  input  wire logic [11:0]   aux_sense_mv,
  input  wire logic [9:0]    bulk_sense_current,
  input  wire logic          bulk_valid,
  input  wire logic [LW-1:0] peak_cmd,
  input  wire logic          ss_restart,
  input  wire logic          feedback_pin_low,
  input  wire logic          cycle_peak_comparator,
  input  wire logic          second_comparator,
  // Results
  output logic [LW-1:0]      threshold,
  output logic               switch_off,
  output logic               second_trip
);

  // Time counts derived from the clock rate
  localparam int LEB_CYC = (`PCL_LEB_NS * `PCL_CLK_MHZ + `PCL_NS_PER_US - 1)
                           / `PCL_NS_PER_US;
  localparam int RS_CYC  = (`PCL_RS_NS * `PCL_CLK_MHZ + `PCL_NS_PER_US - 1)
                           / `PCL_NS_PER_US;
  localparam int TW      = $clog2(BASE_CYCLES + 1);
  localparam int SPAN    = `PCL_HL_UA - `PCL_LL_UA;

  // Elaboration check on parameters
  if (LW < 8 || LW > 16 || BASE_CYCLES < 1) begin : g_bad
    $error("pcl_limit: unsupported parameter values");
  end

  // Both timers are eight bits wide; longer times need wider counters
  if (LEB_CYC > 255 || RS_CYC < 1 || RS_CYC > 256) begin : g_bad_time
    $error("pcl_limit: timer counts do not fit the counters");
  end

  // Register map decode shared by read and write paths
  function automatic logic [3:0] reg_index(input logic [7:0] a);
    unique case (a)
      `PCL_OFS_CTRL:   reg_index = 4'h0;
      `PCL_OFS_SLOPE:  reg_index = 4'h1;
      `PCL_OFS_ZERO:   reg_index = 4'h2;
      `PCL_OFS_RSTART: reg_index = 4'h3;
      `PCL_OFS_REND:   reg_index = 4'h4;
      `PCL_OFS_PDC:    reg_index = 4'h5;
      `PCL_OFS_STEP:   reg_index = 4'h6;
      `PCL_OFS_STATUS: reg_index = 4'h7;
      `PCL_OFS_LIMIT:  reg_index = 4'h8;
      default:         reg_index = 4'hf;
    endcase
  endfunction

  pcl_pkg::pcl_aphase_s ap_q;
  logic [15:0]          slope_q;
  logic [7:0]           zero_q;
  logic [LW-1:0]        rstart_q;
  logic [LW-1:0]        rend_q;
  logic [LW-1:0]        pdc_q;
  logic [LW-1:0]        step_q;
  logic                 ss_kick_q;
  logic                 wr_en;
  logic [3:0]           wr_idx;

  // Address phase capture, zero wait states, always OKAY
  // Only a selected NONSEQ or SEQ seen with hready high starts a transfer
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ap_q <= '0;
    end else if (hready) begin
      ap_q.wr   <= hsel && htrans[1] && hwrite;
      ap_q.rd   <= hsel && htrans[1] && !hwrite;
      ap_q.addr <= haddr[7:0];
    end
  end

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign wr_en     = ap_q.wr;
  assign wr_idx    = reg_index(ap_q.addr);

  // Software-written configuration
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      slope_q   <= `PCL_RST_SLOPE;
      zero_q    <= `PCL_RST_ZERO;
      rstart_q  <= LW'(`PCL_RST_RSTART);
      rend_q    <= LW'(`PCL_RST_REND);
      pdc_q     <= LW'(`PCL_RST_PDC);
      step_q    <= LW'(`PCL_RST_STEP);
      ss_kick_q <= 1'b0;
    end else begin
      ss_kick_q <= wr_en && (wr_idx == 4'h0) && hwdata[0];
      if (wr_en) begin
        unique case (wr_idx)
          4'h1: slope_q  <= hwdata[15:0];
          4'h2: zero_q   <= hwdata[7:0];
          4'h3: rstart_q <= hwdata[LW-1:0];
          4'h4: rend_q   <= hwdata[LW-1:0];
          4'h5: pdc_q    <= hwdata[LW-1:0];
          4'h6: step_q   <= hwdata[LW-1:0];
          default: ;
        endcase
      end
    end
  end

  // Ringing suppression timer after gate turn-off
  // A new turn-on cancels a pending sample, the winding is no longer valid
  logic       gate_q;
  logic [7:0] rs_cnt_q;
  logic       rs_run_q;
  logic       sample_now;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      gate_q   <= 1'b0;
      rs_run_q <= 1'b0;
      rs_cnt_q <= 8'h00;
    end else begin
      gate_q <= gate_on;
      if (gate_q && !gate_on) begin
        rs_run_q <= 1'b1;
        rs_cnt_q <= 8'(RS_CYC - 1);
      end else if (gate_on) begin
        rs_run_q <= 1'b0;
      end else if (rs_run_q) begin
        if (rs_cnt_q == 8'h00) begin
          rs_run_q <= 1'b0;
        end else begin
          rs_cnt_q <= rs_cnt_q - 8'h01;
        end
      end
    end
  end

  assign sample_now = rs_run_q && (rs_cnt_q == 8'h00) && !gate_on;

  // Base level removal and saturating conversion
  logic [12:0] above_mv;
  logic [20:0] scaled;
  logic [7:0]  sense_code;

  always_comb begin
    above_mv = 13'(aux_sense_mv) - 13'(`PCL_ADC_BASE_MV);
    scaled   = 21'((21'(above_mv[11:0]) * 21'(`PCL_ADC_NUM))
                   / 21'(`PCL_ADC_DEN));
    if (above_mv[12]) begin
      sense_code = 8'h00;
    end else if (scaled > 21'(`PCL_ADC_MAX)) begin
      sense_code = 8'hff;
    end else begin
      sense_code = scaled[7:0];
    end
  end

  // Offset from each new sense sample
  // Held between samples so the limit never follows the winding ringing
  logic [7:0]  code_q;
  logic [LW-1:0] offset_q;
  logic [23:0] prod;

  assign prod = (zero_q > sense_code)
              ? 24'(slope_q) * 24'(zero_q - sense_code)
              : 24'h000000;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      code_q   <= 8'h00;
      offset_q <= '0;
    end else if (sample_now) begin
      code_q   <= sense_code;
      offset_q <= LW'(prod >> `PCL_OFS_SHIFT);
    end
  end

  // Bulk sense current, clamped to the line corners
  // Readings beyond a corner are held there, never extrapolated
  logic [9:0] bulk_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bulk_q <= 10'(`PCL_LL_UA);
    end else if (bulk_valid) begin
      if (bulk_sense_current < 10'(`PCL_LL_UA)) begin
        bulk_q <= 10'(`PCL_LL_UA);
      end else if (bulk_sense_current > 10'(`PCL_HL_UA)) begin
        bulk_q <= 10'(`PCL_HL_UA);
      end else begin
        bulk_q <= bulk_sense_current;
      end
    end
  end

  // Soft-start ramp
  // A restart wins over a ramp step and over the feedback exit
  pcl_pkg::pcl_ss_e ss_q;
  logic [LW-1:0]    ss_lvl_q;
  logic [TW-1:0]    base_q;
  logic [LW:0]      ss_next;

  assign ss_next = {1'b0, ss_lvl_q} + {1'b0, step_q};

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ss_q     <= pcl_pkg::PCL_SS_RAMP;
      ss_lvl_q <= LW'(`PCL_RST_RSTART);
      base_q   <= '0;
    end else if (ss_restart || ss_kick_q) begin
      ss_q     <= pcl_pkg::PCL_SS_RAMP;
      ss_lvl_q <= rstart_q;
      base_q   <= '0;
    end else begin
      unique case (ss_q)
        pcl_pkg::PCL_SS_IDLE: begin
          base_q <= '0;
        end
        pcl_pkg::PCL_SS_RAMP: begin
          if (feedback_pin_low) begin
            ss_q <= pcl_pkg::PCL_SS_IDLE;
          end else if (ss_lvl_q >= rend_q) begin
            ss_q <= pcl_pkg::PCL_SS_IDLE;
          end else if (base_q == TW'(BASE_CYCLES - 1)) begin
            base_q <= '0;
            ss_lvl_q <= (ss_next > {1'b0, rend_q}) ? rend_q
                                                   : ss_next[LW-1:0];
          end else begin
            base_q <= base_q + 1'b1;
          end
        end
      endcase
    end
  end

  // Offset and delay compensation applied to the command
  logic [LW-1:0] lim_ofs;
  logic [LW-1:0] pdc_amt;
  logic [LW+9:0] pdc_prod;

  always_comb begin
    lim_ofs  = (peak_cmd > offset_q) ? peak_cmd - offset_q : '0;
    pdc_prod = (LW+10)'(pdc_q) * (LW+10)'(bulk_q - 10'(`PCL_LL_UA));
    pdc_amt  = LW'(pdc_prod / (LW+10)'(SPAN));
  end

  // Threshold register: ramp level or compensated limit
  // Ramp levels bypass delay compensation, they are final numbers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      threshold <= '0;
    end else if (ss_q == pcl_pkg::PCL_SS_RAMP) begin
      threshold <= ss_lvl_q;
    end else begin
      threshold <= (lim_ofs > pdc_amt) ? lim_ofs - pdc_amt : '0;
    end
  end

  // Turn-on blanking of the cycle peak comparator
  // Restarted on every rising gate edge, so the spike ringing is masked too
  logic [7:0] leb_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      leb_q <= 8'h00;
    end else if (gate_on && !gate_q) begin
      leb_q <= 8'(LEB_CYC);
    end else if (leb_q != 8'h00) begin
      leb_q <= leb_q - 8'h01;
    end
  end

  // Turn-off request and unblanked second comparator
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      switch_off  <= 1'b0;
      second_trip <= 1'b0;
    end else begin
      switch_off  <= gate_on && gate_q && (leb_q == 8'h00)
                     && cycle_peak_comparator;
      second_trip <= second_comparator;
    end
  end

  // Read data for the data phase
  // Captured at the address edge, so it stands through the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h00000000;
    end else if (hready && hsel && htrans[1] && !hwrite) begin
      unique case (reg_index(haddr[7:0]))
        4'h1: hrdata <= {16'h0000, slope_q};
        4'h2: hrdata <= {24'h000000, zero_q};
        4'h3: hrdata <= 32'(rstart_q);
        4'h4: hrdata <= 32'(rend_q);
        4'h5: hrdata <= 32'(pdc_q);
        4'h6: hrdata <= 32'(step_q);
        4'h7: hrdata <= {7'h00, ss_q == pcl_pkg::PCL_SS_RAMP,
                         code_q, 6'h00, bulk_q};
        4'h8: hrdata <= {6'h00, 10'(offset_q), 6'h00, 10'(threshold)};
        default: hrdata <= 32'h00000000;
      endcase
    end
  end

endmodule // pcl_limit

// >>> pcl_limit_assertions.sv
// Port assertions for the peak current limit block
`timescale 1ns/1ps
module pcl_limit_chk #(
  parameter int LW = 10
) (
  // Clock and reset
  input wire logic          hclk,
  input wire logic          hresetn,
  // Stage and sense inputs
  input wire logic          gate_on,
  input wire logic          feedback_pin_low,
  input wire logic          cycle_peak_comparator,
  input wire logic          second_comparator,
  // Results
  input wire logic [LW-1:0] threshold,
  input wire logic          switch_off,
  input wire logic          second_trip
);
  logic [5:0] on_q;
  logic       run_q;
  logic       ramp_q;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // On-time count, and the first ramp after each reset
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      on_q   <= 6'h00;
      run_q  <= 1'b0;
      ramp_q <= 1'b0;
    end else begin
      on_q   <= gate_on ? on_q + {5'h00, ~&on_q} : 6'h00;
      run_q  <= 1'b1;
      ramp_q <= (ramp_q | !run_q) & !feedback_pin_low
                & (threshold < 10'h100);
    end
  end
  sequence s_armed;
    gate_on && on_q > 6'd30 && cycle_peak_comparator;
  endsequence
  sequence s_early;
    $rose(gate_on) ##1 second_comparator;
  endsequence
  chk_trip_cause: assert property (switch_off |->
    $past(gate_on) && $past(cycle_peak_comparator))
    else $error("switch off without a trip");
  chk_trip_armed: assert property (s_armed |-> ##[1:2] switch_off)
    else $error("no trip after blanking");
  chk_blank_min: assert property (switch_off |-> on_q >= 6'd29)
    else $error("trip inside blanking");
  chk_second_free: assert property (s_early |=> second_trip)
    else $error("second comparator blanked");
  chk_ramp_start: assert property ($rose(hresetn) |=>
    threshold == 10'h020) else $error("bad ramp start");
  chk_ramp_step: assert property (ramp_q && $past(ramp_q)
    && $changed(threshold) |->
    threshold == $past(threshold) + 10'h001)
    else $error("bad ramp step");
  chk_ramp_ceil: assert property (ramp_q |-> threshold <= 10'h100)
    else $error("ramp above end level");
  chk_ramp_fixed: assert property (ramp_q |-> threshold >= 10'h020)
    else $error("ramp level reduced");
endmodule // pcl_limit_chk
bind pcl_limit pcl_limit_chk #(.LW(LW)) u_chk (.hclk(hclk),
  .hresetn(hresetn), .gate_on(gate_on),
  .feedback_pin_low(feedback_pin_low),
  .cycle_peak_comparator(cycle_peak_comparator),
  .second_comparator(second_comparator), .threshold(threshold),
  .switch_off(switch_off), .second_trip(second_trip));

// >>> pcl_stage_model.sv
// Power stage model: switch period, current ramp, turn-on spike
`timescale 1ns/1ps
module pcl_stage_model (
  // Clock and reset
  input  wire logic       hclk,
  input  wire logic       hresetn,
  // Limit and trip from the block
  input  wire logic [9:0] threshold,
  input  wire logic       switch_off,
  // Gate and sensed peak comparison
  output logic            gate_on,
  output logic            cycle_peak_comparator
);
  logic [7:0] t_q;
  // On until a trip or 120 cycles, then off for 80 cycles
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      gate_on <= 1'b0;
      t_q     <= 8'h00;
    end else if (gate_on && (switch_off || t_q == 8'h77)) begin
      gate_on <= 1'b0;
      t_q     <= 8'h00;
    end else if (!gate_on && t_q == 8'h4f) begin
      gate_on <= 1'b1;
      t_q     <= 8'h00;
    end else begin
      t_q <= t_q + 8'h01;
    end
  end
  // Spike for 6 cycles after turn-on, then 8 codes a cycle
  assign cycle_peak_comparator = gate_on
    && (t_q < 8'h06 || {t_q, 3'b000} >= {1'b0, threshold});
endmodule // pcl_stage_model

// >>> tb.sv
// Self-checking bench for the peak current limit block
`timescale 1ns/1ps
module tb;
  logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic        gate_on, bulk_valid, ss_restart, feedback_pin_low;
  logic        cycle_peak_comparator, second_comparator;
  logic        switch_off, second_trip;
  logic [11:0] aux_sense_mv;
  logic [9:0]  bulk_sense_current, peak_cmd, threshold;
  int          miscompares, n_checks, n;
  logic [9:0]  bv[3] = '{10'd220, 10'd400, 10'd0};
  logic [9:0]  bt[3] = '{10'h176, 10'h16b, 10'h180};
  logic [11:0] av[5] = '{12'd1200, 12'd1000, 12'd1500, 12'd1694, 12'd3000};
  logic [7:0]  ac[5] = '{8'd0, 8'd0, 8'd48, 8'd79, 8'd255};
  logic [5:0]  ao[5] = '{6'd24, 6'd24, 6'd9, 6'd0, 6'd0};
  logic [31:0] rv[6] = '{32'h4e20, 32'h4f, 32'h20, 32'h100, 32'h15, 32'h1};
  assign hready = hreadyout;
  pcl_limit #(.BASE_CYCLES(8), .LW(10)) uut (.hclk(hclk),
    .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .gate_on(gate_on), .aux_sense_mv(aux_sense_mv),
    .bulk_sense_current(bulk_sense_current), .bulk_valid(bulk_valid),
    .peak_cmd(peak_cmd), .ss_restart(ss_restart),
    .feedback_pin_low(feedback_pin_low),
    .cycle_peak_comparator(cycle_peak_comparator),
    .second_comparator(second_comparator), .threshold(threshold),
    .switch_off(switch_off), .second_trip(second_trip));
  pcl_stage_model u_stage (.hclk(hclk), .hresetn(hresetn),
    .threshold(threshold), .switch_off(switch_off), .gate_on(gate_on),
    .cycle_peak_comparator(cycle_peak_comparator));
  // 100 MHz clock
  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end
  // Counts a comparison, reports a mismatch
  task automatic chk(input string nm, input logic [31:0] s, e);
    n_checks++;
    if (s !== e) begin
      miscompares++;
      $display("MISMATCH %s exp %h seen %h", nm, e, s);
    end
  endtask
  task automatic tick(input int c);
    repeat (c) @(posedge hclk);
  endtask
  // One single AHB-Lite word transfer; read data lands in rd
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
    @(posedge hclk);
    haddr <= {24'h000000, a};
    hwrite <= w;
    htrans <= 2'h2;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    rd = hrdata;
    chk("okay", {31'h0, hresp}, 32'h0);
  endtask
  task automatic bulk(input logic [9:0] ua);
    @(posedge hclk);
    bulk_sense_current <= ua;
    bulk_valid <= 1'b1;
    @(posedge hclk);
    bulk_valid <= 1'b0;
  endtask
  task automatic summarize;
    if (miscompares == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // Watchdog
  initial begin
    #200000;
    miscompares++;
    summarize();
  end
  // Main sequence
  initial begin
    {hresetn, hwrite, bulk_valid, ss_restart} = 4'h0;
    {feedback_pin_low, second_comparator} = 2'h0;
    {hsel, hsize, htrans, haddr, hwdata} = {1'b1, 3'h2, 66'h0};
    {aux_sense_mv, bulk_sense_current, peak_cmd} = {12'd3000, 10'd0, 10'h180};
    {miscompares, n_checks, n} = 96'h0;
    tick(8);
    hresetn <= 1'b1;
    bulk(10'd370);
    while (threshold !== 10'h100 && n < 4000) begin
      tick(1);
      n++;
    end
    chk("ramp time", {31'h0, n > 1770 && n < 1810}, 32'h1);
    for (int i = 0; i < 3; i++) begin
      bulk(bv[i]);
      tick(3);
      chk("pdc", {22'h0, threshold}, {22'h0, bt[i]});
    end
    for (int i = 0; i < 6; i++) begin
      xfer(1'b0, 8'h04 + 8'(4 * i), 32'h0);
      chk("reset value", rd, rv[i]);
    end
    for (int i = 0; i < 5; i++) begin
      aux_sense_mv <= av[i];
      tick(450);
      xfer(1'b0, 8'h1c, 32'h0);
      chk("code", {24'h0, rd[23:16]}, {24'h0, ac[i]});
      xfer(1'b0, 8'h20, 32'h0);
      chk("offset", {22'h0, rd[25:16]}, {26'h0, ao[i]});
      chk("limit", {22'h0, threshold}, 32'h180 - ao[i]);
    end
    aux_sense_mv <= 12'd1200;
    peak_cmd <= 10'd10;
    tick(450);
    chk("clamp", {22'h0, threshold}, 32'h0);
    peak_cmd <= 10'h180;
    xfer(1'b1, 8'h08, 32'h30);
    xfer(1'b0, 8'h08, 32'h0);
    chk("zero", rd, 32'h30);
    tick(450);
    chk("zero limit", {22'h0, threshold}, 32'h172);
    xfer(1'b0, 8'h40, 32'h0);
    chk("unmapped", rd, 32'h0);
    bulk(10'd370);
    ss_restart <= 1'b1;
    tick(1);
    ss_restart <= 1'b0;
    tick(2);
    chk("restart", {22'h0, threshold}, 32'h20);
    feedback_pin_low <= 1'b1;
    tick(3);
    chk("fb end", {22'h0, threshold}, 32'h15d);
    feedback_pin_low <= 1'b0;
    xfer(1'b1, 8'h00, 32'h1);
    tick(3);
    chk("ctrl restart", {22'h0, threshold}, 32'h20);
    @(posedge gate_on);
    tick(1);
    second_comparator <= 1'b1;
    tick(3);
    chk("second", {31'h0, second_trip}, 32'h1);
    chk("blank", {31'h0, switch_off}, 32'h0);
    second_comparator <= 1'b0;
    summarize();
  end
endmodule // tb
